/* File: design/sdbr_err_capture.sv */
`timescale 1ns/100ps
`default_nettype none
module sdbr_err_capture
	import sdbr_pkg::*;
(
	input wire logic aclk, // System clock.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic dma_reset, // Receive DMA reset pulse.
	input wire logic buf_load, // Buffer loaded pulse.
	input wire logic buf_unload, // Buffer unloaded pulse.
	input wire logic byte_err, // Erroneous byte stored pulse.
	input wire logic [FIELD_W-1:0] byte_offset, // Offset of that byte.
	output logic [FIELD_W-1:0] first_error // Captured offset.
);

	logic captured;
	logic unloaded;

	// Remembers an unload so that only the following load re-arms.
	always_ff @(posedge aclk) begin
		if (!aresetn || dma_reset) begin
			unloaded <= 1'b0;
		end else if (buf_unload) begin
			unloaded <= 1'b1;
		end else if (buf_load) begin
			unloaded <= 1'b0;
		end
	end

	// Holds the first error offset; zero until one is seen.
	always_ff @(posedge aclk) begin
		if (!aresetn || dma_reset) begin
			first_error <= ERR_RESET;
			captured <= 1'b0;
		end else if (buf_load && unloaded) begin
			first_error <= ERR_RESET;
			captured <= 1'b0;
		end else if (byte_err && !captured) begin
			first_error <= byte_offset;
			captured <= 1'b1;
		end
	end

endmodule
`default_nettype wire

/* File: design/sdbr_events.sv */
`timescale 1ns/100ps
`default_nettype none
module sdbr_events
	import sdbr_pkg::*;
(
	input wire logic aclk, // System clock.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic [EVT_W-1:0] event_in, // Event pulses.
	input wire logic [EVT_W-1:0] clear, // Clear pulses from software.
	input wire logic [EVT_W-1:0] enable, // Enable mask as it will stand.
	output logic [EVT_W-1:0] pending, // Sticky pending flags.
	output logic irq // Level interrupt request.
);

	// One sticky flag per event; a new event beats a clear.
	for (genvar i = 0; i < EVT_W; i++) begin : g_flag
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pending[i] <= 1'b0;
			end else if (event_in[i]) begin
				pending[i] <= 1'b1;
			end else if (clear[i]) begin
				pending[i] <= 1'b0;
			end
		end
	end

	// Registered request from the next flags and the next mask.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((pending & ~clear) | event_in) & enable);
		end
	end

endmodule
`default_nettype wire

/* File: design/sdbr_pkg.sv */
package sdbr_pkg;

	// Bus geometry; every register index is scaled by four.
	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;
	localparam int IDX_W = 16;

	// Field widths.
	localparam int FIELD_W = 13;
	localparam int EVT_W = 13;
	localparam int NUM_ADDR = 8;

	// Register indexes as printed; byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_RX_A_START = 16'h4400;
	localparam logic [IDX_W-1:0] IDX_RX_A_END = 16'h4402;
	localparam logic [IDX_W-1:0] IDX_RX_B_START = 16'h4404;
	localparam logic [IDX_W-1:0] IDX_RX_B_END = 16'h4406;
	localparam logic [IDX_W-1:0] IDX_TX_A_START = 16'h4408;
	localparam logic [IDX_W-1:0] IDX_TX_A_END = 16'h440a;
	localparam logic [IDX_W-1:0] IDX_TX_B_START = 16'h440c;
	localparam logic [IDX_W-1:0] IDX_TX_B_END = 16'h440e;
	localparam logic [IDX_W-1:0] IDX_RX_A_FIRST_ERROR = 16'h441a;
	localparam logic [IDX_W-1:0] IDX_RX_B_FIRST_ERROR = 16'h441c;
	localparam logic [IDX_W-1:0] IDX_EVENT_PENDING = 16'h460e;
	localparam logic [IDX_W-1:0] IDX_EVENT_CLEAR = 16'h4610;
	localparam logic [IDX_W-1:0] IDX_EVENT_ENABLE = 16'h4626;

	// Bits 15:13 of every buffer address register.
	localparam logic [2:0] ADDR_TOP_BITS = 3'h3;

	// Reset values.
	localparam logic [FIELD_W-1:0] ADDR_RESET = 13'h0000;
	localparam logic [FIELD_W-1:0] ERR_RESET = 13'h0000;
	localparam logic [EVT_W-1:0] EVT_RESET = 13'h0000;

	// Event bit positions, shared by pending, clear and enable.
	localparam int EVT_RX_DATA = 0;
	localparam int EVT_TX_FREE = 1;
	localparam int EVT_TX_IDLE = 2;
	localparam int EVT_RX_OVERRUN = 3;
	localparam int EVT_TX_UNDERRUN = 4;
	localparam int EVT_RX_OP_DONE = 5;
	localparam int EVT_TX_OP_DONE = 6;
	localparam int EVT_COMMAND_DONE = 7;
	localparam int EVT_NACK = 8;
	localparam int EVT_RX_A_UNLOADED = 9;
	localparam int EVT_RX_B_UNLOADED = 10;
	localparam int EVT_TX_A_UNLOADED = 11;
	localparam int EVT_TX_B_UNLOADED = 12;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: design/sdbr_regs.sv */
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module sdbr_regs
	import sdbr_pkg::*;
(
	input wire logic aclk, // System clock, 20 MHz.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
	input wire logic [2:0] s_axi_awprot, // Write protection, unused.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [DATA_W-1:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
	input wire logic [2:0] s_axi_arprot, // Read protection, unused.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [DATA_W-1:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	input wire logic rx_dma_reset, // Receive DMA reset pulse.
	input wire logic rx_a_load, // Receive buffer A loaded pulse.
	input wire logic rx_b_load, // Receive buffer B loaded pulse.
	input wire logic rx_a_byte_err, // Errored byte into buffer A.
	input wire logic rx_b_byte_err, // Errored byte into buffer B.
	input wire logic [FIELD_W-1:0] rx_byte_offset, // Offset of that byte.
	input wire logic [EVT_W-1:0] serial_event, // Event pulses, pending layout.
	output logic [FIELD_W-1:0] rx_buf_a_start, // Receive A first address.
	output logic [FIELD_W-1:0] rx_buf_a_end, // Receive A last address.
	output logic [FIELD_W-1:0] rx_buf_b_start, // Receive B first address.
	output logic [FIELD_W-1:0] rx_buf_b_end, // Receive B last address.
	output logic [FIELD_W-1:0] tx_buf_a_start, // Transmit A first address.
	output logic [FIELD_W-1:0] tx_buf_a_end, // Transmit A last address.
	output logic [FIELD_W-1:0] tx_buf_b_start, // Transmit B first address.
	output logic [FIELD_W-1:0] tx_buf_b_end, // Transmit B last address.
	output logic irq // Level interrupt, high while enabled flag set.
);

	// Printed index of each buffer address register, in slot order.
	// Slot order is also the order of the address outputs below, so a
	// slot number names one register in decode, storage and read-back.
	localparam logic [IDX_W-1:0] ADDR_IDX [NUM_ADDR] = '{
		IDX_RX_A_START, IDX_RX_A_END, IDX_RX_B_START, IDX_RX_B_END,
		IDX_TX_A_START, IDX_TX_A_END, IDX_TX_B_START, IDX_TX_B_END
	};

	// Bus channel state, decode results and the event and error fields.
	logic [FIELD_W-1:0] buf_addr [NUM_ADDR];
	logic [IDX_W-1:0] aw_idx;
	logic aw_held;
	logic [15:0] w_data;
	logic [1:0] w_strb;
	logic w_held;
	logic wr_fire;
	logic [IDX_W-1:0] ar_idx;
	logic [DATA_W-1:0] next_rdata;
	logic next_rhit;
	logic wr_hit;
	logic [EVT_W-1:0] event_enable;
	logic [EVT_W-1:0] next_event_enable;
	logic [EVT_W-1:0] event_clear;
	logic [EVT_W-1:0] event_pending;
	logic [FIELD_W-1:0] rx_a_first_error;
	logic [FIELD_W-1:0] rx_b_first_error;
	logic [FIELD_W-1:0] strobed;
	logic [EVT_W-1:0] strobed_evt;

	// Byte address to register index; the two low bits are ignored, as
	// every register takes one aligned word.
	assign ar_idx = s_axi_araddr[ADDR_W-1:2];

	// A write is carried out once both address and data are held.
	// The response flag blocks a second firing while the answer waits,
	// since both halves stay held until the response is taken; without
	// it the same word would be applied again in every waiting cycle.
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;

	// Merges the held write data into a 13-bit field under the strobes.
	// Strobe 0 carries bits 7:0 and strobe 1 bits 12:8; bits 15:13 of
	// the bus word are dropped here, which keeps the fixed bits fixed.
	function automatic logic [FIELD_W-1:0] merge13(
		input logic [FIELD_W-1:0] old,
		input logic [15:0] data,
		input logic [1:0] strb
	);
		logic [FIELD_W-1:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[12:8] = data[12:8];
		end
		return res;
	endfunction

	// Write address channel: taken when idle, released after response.
	// Ready falls at the edge that takes the address and rises again at
	// the edge that takes the response, so one write is open at a time.
	// A second address offered meanwhile simply waits for ready.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_idx <= '0;
			s_axi_awready <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_idx <= s_axi_awaddr[ADDR_W-1:2];
			s_axi_awready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			aw_held <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	// Write data channel, independent of the address channel.
	// Data may arrive before, with or after the address; the write only
	// fires once both halves are held.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_wready <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata[15:0];
			w_strb <= s_axi_wstrb[1:0];
			s_axi_wready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			w_held <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	// Decides whether the held write address names a writable register.
	// The error offsets and the pending flags are read-only, so a write
	// to them misses and is answered with an error response.
	always_comb begin
		wr_hit = 1'b0;
		for (int k = 0; k < NUM_ADDR; k++) begin
			if (aw_idx == ADDR_IDX[k]) begin
				wr_hit = 1'b1;
			end
		end
		if (aw_idx == IDX_EVENT_ENABLE || aw_idx == IDX_EVENT_CLEAR) begin
			wr_hit = 1'b1;
		end
	end

	// Write response: OKAY for a writable register, SLVERR otherwise.
	// The response is raised one edge after the write fires and stands
	// until the master takes it; a missed write changes no register.
	// The same edge that raises it also updates the written register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Buffer address registers, one per slot; bits 15:13 are not stored.
	// The constant top bits are added back only on the read path, so the
	// DMA engines see just the 13 address bits.
	for (genvar k = 0; k < NUM_ADDR; k++) begin : g_addr
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				buf_addr[k] <= ADDR_RESET;
			end else if (wr_fire && aw_idx == ADDR_IDX[k]) begin
				buf_addr[k] <= merge13(buf_addr[k], w_data, w_strb);
			end
		end
	end

	// Drives the address spans to the DMA engines straight from flops.
	// These are plain wires from the slots, so no logic sits between a
	// register and its output.
	assign rx_buf_a_start = buf_addr[0];
	assign rx_buf_a_end = buf_addr[1];
	assign rx_buf_b_start = buf_addr[2];
	assign rx_buf_b_end = buf_addr[3];
	assign tx_buf_a_start = buf_addr[4];
	assign tx_buf_a_end = buf_addr[5];
	assign tx_buf_b_start = buf_addr[6];
	assign tx_buf_b_end = buf_addr[7];

	// Next value of the enable mask. The request flop looks at it, so a
	// mask write reaches the request at the same edge as the register,
	// and a flag whose enable was cleared never holds the request up.
	always_comb begin
		next_event_enable = event_enable;
		if (wr_fire && aw_idx == IDX_EVENT_ENABLE) begin
			next_event_enable = merge13(event_enable, w_data,
				w_strb);
		end
	end

	// Enable mask; only bits 12:0 exist, so 15:13 read back as zero.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			event_enable <= EVT_RESET;
		end else begin
			event_enable <= next_event_enable;
		end
	end

	// A write of ones to the clear register drops those pending flags.
	// The clear lasts only for the cycle in which the write fires, and
	// an event in that same cycle still wins over it.
	assign strobed = merge13(EVT_RESET, w_data, w_strb);
	assign strobed_evt = strobed;
	assign event_clear = (wr_fire && aw_idx == IDX_EVENT_CLEAR) ?
		strobed_evt : EVT_RESET;

	// Sticky event flags and the combined interrupt request.
	// The request is registered from the next flags and the next mask,
	// so it equals the enabled pending flags in every cycle.
	sdbr_events u_events (
		.aclk(aclk),
		.aresetn(aresetn),
		.event_in(serial_event),
		.clear(event_clear),
		.enable(next_event_enable),
		.pending(event_pending),
		.irq(irq)
	);

	// First-error capture for receive buffer A.
	// The buffer-unloaded event is the unload half of the re-arm pair;
	// the load pulse from the receive engine is the other half.
	sdbr_err_capture u_err_a (
		.aclk(aclk),
		.aresetn(aresetn),
		.dma_reset(rx_dma_reset),
		.buf_load(rx_a_load),
		.buf_unload(serial_event[EVT_RX_A_UNLOADED]),
		.byte_err(rx_a_byte_err),
		.byte_offset(rx_byte_offset),
		.first_error(rx_a_first_error)
	);

	// First-error capture for receive buffer B.
	// It shares the offset bus with buffer A, as only one buffer is
	// filled at a time.
	sdbr_err_capture u_err_b (
		.aclk(aclk),
		.aresetn(aresetn),
		.dma_reset(rx_dma_reset),
		.buf_load(rx_b_load),
		.buf_unload(serial_event[EVT_RX_B_UNLOADED]),
		.byte_err(rx_b_byte_err),
		.byte_offset(rx_byte_offset),
		.first_error(rx_b_first_error)
	);

	// Read multiplexer; unmapped indexes return zero with SLVERR.
	// The clear register is write-only and reads as zero; the read-only
	// registers are zero-extended from their 13 bits.
	// Address registers show their fixed top bits above the field.
	always_comb begin
		next_rdata = '0;
		next_rhit = 1'b1;
		unique case (ar_idx)
			IDX_RX_A_START, IDX_RX_A_END, IDX_RX_B_START, IDX_RX_B_END,
			IDX_TX_A_START, IDX_TX_A_END, IDX_TX_B_START,
			IDX_TX_B_END: begin
				for (int k = 0; k < NUM_ADDR; k++) begin
					if (ar_idx == ADDR_IDX[k]) begin
						next_rdata[15:0] = {ADDR_TOP_BITS, buf_addr[k]};
					end
				end
			end
			IDX_RX_A_FIRST_ERROR: begin
				next_rdata[FIELD_W-1:0] = rx_a_first_error;
			end
			IDX_RX_B_FIRST_ERROR: begin
				next_rdata[FIELD_W-1:0] = rx_b_first_error;
			end
			IDX_EVENT_PENDING: begin
				next_rdata[EVT_W-1:0] = event_pending;
			end
			IDX_EVENT_CLEAR: begin
				next_rdata = '0;
			end
			IDX_EVENT_ENABLE: begin
				next_rdata[EVT_W-1:0] = event_enable;
			end
			default: begin
				next_rhit = 1'b0;
			end
		endcase
	end

	// Read address channel: one read at a time.
	// Ready stays low from the edge that takes an address until the edge
	// that takes its data, which holds off a second read meanwhile.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
		end
	end

	// Read data channel, registered one cycle after the address is taken.
	// Data are captured at the taking edge and stand until taken, so a
	// later register change does not alter an answer in flight.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rhit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* File: dv/sdbr_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module sdbr_assertions
	import sdbr_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [EVT_W-1:0] serial_event,
	input wire logic irq,
	input wire logic [FIELD_W-1:0] rx_buf_a_end,
	input wire logic [FIELD_W-1:0] tx_buf_a_start,
	input wire logic [FIELD_W-1:0] tx_buf_b_end
);
	logic [IDX_W-1:0] ridx;

	// Keeps the index of the read in flight to judge its data.
	always_ff @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready) begin
			ridx <= s_axi_araddr[ADDR_W-1:2];
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	b_after_take_a: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response missing");
	b_done_a: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write channel not freed");
	r_after_take_a: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	r_done_a: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid && s_axi_arready) else $error("read channel stuck");
	field_hold_a: assert property ($changed({rx_buf_a_end,
		tx_buf_a_start, tx_buf_b_end}) |-> $rose(s_axi_bvalid))
		else $error("field changed without write");
	irq_rise_a: assert property ($rose(irq) |->
		$past(|serial_event) || s_axi_bvalid) else $error("irq rose alone");
	irq_fall_a: assert property ($fell(irq) |-> s_axi_bvalid)
		else $error("irq fell alone");
	addr_top_a: assert property (s_axi_rvalid && !ridx[0] &&
		ridx >= IDX_RX_A_START && ridx <= IDX_TX_B_END |->
		s_axi_rdata[31:13] == 19'h3) else $error("address top bits");
	err_top_a: assert property (s_axi_rvalid &&
		(ridx == IDX_RX_A_FIRST_ERROR || ridx == IDX_RX_B_FIRST_ERROR) |->
		s_axi_rdata[31:13] == '0 && s_axi_rresp == RESP_OKAY)
		else $error("error offset shape");
	en_top_a: assert property (s_axi_rvalid &&
		ridx == IDX_EVENT_ENABLE |-> s_axi_rdata[31:13] == '0)
		else $error("enable top bits");

	cover property (irq);
	cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	cover property ($changed(tx_buf_b_end));
endmodule

bind sdbr_regs sdbr_assertions u_chk (.*);
`default_nettype wire

/* File: dv/sdbr_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sdbr_far_model
	import sdbr_pkg::*;
(
	input wire logic aclk, // System clock.
	output logic rx_dma_reset, // Receive DMA reset.
	output logic rx_a_load, // Buffer A loaded.
	output logic rx_b_load, // Buffer B loaded.
	output logic rx_a_byte_err, // Errored byte into A.
	output logic rx_b_byte_err, // Errored byte into B.
	output logic [FIELD_W-1:0] rx_byte_offset, // Errored byte offset.
	output logic [EVT_W-1:0] serial_event // Event pulses.
);
	// Strobes idle low from time zero.
	initial begin
		{rx_dma_reset, rx_a_load, rx_b_load} = '0;
		{rx_a_byte_err, rx_b_byte_err} = '0;
		rx_byte_offset = '1;
		serial_event = '0;
	end

	// One-cycle pulse of the chosen strobes; the offset is inverted after,
	// so a stale value can never pass for a live one.
	task automatic pulse(input logic [4:0] k, input logic [FIELD_W-1:0] off,
		input logic [EVT_W-1:0] ev);
		@(posedge aclk);
		{rx_dma_reset, rx_a_load, rx_b_load, rx_a_byte_err,
			rx_b_byte_err} <= k;
		rx_byte_offset <= off;
		serial_event <= ev;
		@(posedge aclk);
		{rx_dma_reset, rx_a_load, rx_b_load, rx_a_byte_err,
			rx_b_byte_err} <= '0;
		rx_byte_offset <= ~off;
		serial_event <= '0;
	endtask
endmodule
`default_nettype wire

/* File: dv/test_sdbr_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module test_sdbr_regs
	import sdbr_pkg::*;
;
	logic aclk, aresetn, irq;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, rx_dma_reset, rx_a_load, rx_b_load;
	logic rx_a_byte_err, rx_b_byte_err;
	logic [FIELD_W-1:0] rx_byte_offset;
	logic [EVT_W-1:0] serial_event;
	logic [FIELD_W-1:0] rx_buf_a_start, rx_buf_a_end, rx_buf_b_start;
	logic [FIELD_W-1:0] rx_buf_b_end, tx_buf_a_start, tx_buf_a_end;
	logic [FIELD_W-1:0] tx_buf_b_start, tx_buf_b_end;
	logic [8*FIELD_W-1:0] flds;
	int errors, check_count;
	localparam logic [IDX_W-1:0] AIX [8] = '{IDX_RX_A_START, IDX_RX_A_END,
		IDX_RX_B_START, IDX_RX_B_END, IDX_TX_A_START, IDX_TX_A_END,
		IDX_TX_B_START, IDX_TX_B_END};

	sdbr_regs u_dut (.*);
	sdbr_far_model u_far (.*);

	// All address fields side by side, first register highest.
	assign flds = {rx_buf_a_start, rx_buf_a_end, rx_buf_b_start,
		rx_buf_b_end, tx_buf_a_start, tx_buf_a_end, tx_buf_b_start,
		tx_buf_b_end};

	// A 50 ns clock.
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	task automatic test_done;
		$display("errors %0d, checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask

	// A bus wait that used up its bound ends the run.
	task automatic limit(input int n);
		chk(n < 40, "bus timeout");
		if (n >= 40) test_done;
	endtask

	task automatic wr(input logic [IDX_W-1:0] i, input logic [15:0] d,
		input logic [3:0] s, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= {16'h0, d};
		s_axi_wstrb <= s;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 40);
		s_axi_bready <= 1'b0;
		limit(n);
		chk(s_axi_bresp === er, "write response");
	endtask

	task automatic rd(input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] ed,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= {i, 2'h0};
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 40);
		s_axi_rready <= 1'b0;
		limit(n);
		chk(s_axi_rdata === ed && s_axi_rresp === er, "read data");
	endtask

	task automatic t_reset;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (AIX[k]) rd(AIX[k], 32'h6000, RESP_OKAY);
		rd(IDX_RX_A_FIRST_ERROR, '0, RESP_OKAY);
		rd(IDX_RX_B_FIRST_ERROR, '0, RESP_OKAY);
		rd(IDX_EVENT_ENABLE, '0, RESP_OKAY);
		chk(irq === 1'b0 && flds === '0, "reset state");
	endtask

	task automatic t_addr;
		logic [FIELD_W-1:0] v;
		foreach (AIX[k]) begin
			v = FIELD_W'(k * 16'h0321 + 5);
			wr(AIX[k], {3'h7, v}, 4'h3, RESP_OKAY);
			rd(AIX[k], {19'h3, v}, RESP_OKAY);
			chk(flds[(7-k)*FIELD_W +: FIELD_W] === v, "field");
		end
		// Low byte strobe only: bits 12:8 keep their value.
		wr(IDX_TX_B_END, 16'h0000, 4'h1, RESP_OKAY);
		chk(tx_buf_b_end === {v[12:8], 8'h00}, "byte strobe");
		// High byte strobe only: bits 7:0 keep their value.
		wr(IDX_TX_B_END, 16'h1fa5, 4'h2, RESP_OKAY);
		chk(tx_buf_b_end === 13'h1f00, "high strobe");
	endtask

	task automatic t_err;
		u_far.pulse(5'h02, 13'h0123, '0);
		u_far.pulse(5'h02, 13'h0456, '0);
		u_far.pulse(5'h08, 13'h0000, '0);
		rd(IDX_RX_A_FIRST_ERROR, 32'h0123, RESP_OKAY);
		u_far.pulse(5'h00, 13'h0000, 13'h0200);
		u_far.pulse(5'h08, 13'h0000, '0);
		rd(IDX_RX_A_FIRST_ERROR, '0, RESP_OKAY);
		u_far.pulse(5'h02, 13'h1fff, '0);
		u_far.pulse(5'h01, 13'h0001, '0);
		rd(IDX_RX_A_FIRST_ERROR, 32'h1fff, RESP_OKAY);
		rd(IDX_RX_B_FIRST_ERROR, 32'h0001, RESP_OKAY);
		u_far.pulse(5'h10, 13'h0000, '0);
		rd(IDX_RX_A_FIRST_ERROR, '0, RESP_OKAY);
		u_far.pulse(5'h01, 13'h0aaa, '0);
		rd(IDX_RX_B_FIRST_ERROR, 32'h0aaa, RESP_OKAY);
	endtask

	task automatic t_irq;
		logic [EVT_W-1:0] b;
		wr(IDX_EVENT_CLEAR, 16'h1fff, 4'h3, RESP_OKAY);
		for (int k = 0; k < EVT_W; k++) begin
			b = EVT_W'(1) << k;
			wr(IDX_EVENT_ENABLE, {3'h7, b}, 4'h3, RESP_OKAY);
			rd(IDX_EVENT_ENABLE, {19'h0, b}, RESP_OKAY);
			u_far.pulse(5'h00, 13'h0000, ~b);
			@(posedge aclk);
			chk(irq === 1'b0, "masked event");
			rd(IDX_EVENT_PENDING, {19'h0, ~b}, RESP_OKAY);
			u_far.pulse(5'h00, 13'h0000, b);
			@(posedge aclk);
			chk(irq === 1'b1, "enabled event");
			wr(IDX_EVENT_ENABLE, 16'h0000, 4'h3, RESP_OKAY);
			chk(irq === 1'b0, "disabled event");
			wr(IDX_EVENT_ENABLE, {3'h0, b}, 4'h3, RESP_OKAY);
			chk(irq === 1'b1, "re-enabled event");
			wr(IDX_EVENT_CLEAR, 16'h1fff, 4'h3, RESP_OKAY);
			chk(irq === 1'b0, "cleared event");
		end
	endtask

	task automatic t_bad;
		wr(16'h4401, 16'h1fff, 4'h3, RESP_SLVERR);
		rd(16'h4401, '0, RESP_SLVERR);
		wr(IDX_RX_A_FIRST_ERROR, 16'h1fff, 4'h3, RESP_SLVERR);
		rd(IDX_RX_A_FIRST_ERROR, '0, RESP_OKAY);
		rd(IDX_EVENT_CLEAR, '0, RESP_OKAY);
	endtask

	// Main sequence, ending with a second reset.
	initial begin
		errors = 0;
		check_count = 0;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
		{s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		t_reset;
		t_addr;
		t_err;
		t_irq;
		t_bad;
		t_reset;
		test_done;
	end
endmodule
`default_nettype wire
